// ===== erc_ram_cam.sv
// embedded memory block: dual/single-port ram, rom and cam with axi4-lite config
//
// Functional notes
// - bidir mode, any two operations, two ports
// - writes registered; optional output pipeline register
// - simple dual read+write; single port one
// - simple dual: mixed widths only with a one-bit side
// - internal write strobe generated from clock
// - 4096x1 to 512x8; 256x16 in ram modes other than split
// - split into two identical 2048-bit rams
// - input registers and output registers separately enabled
// - per-port read enable, write enable, clear
// - port registers cleared local, global, reset
// - parallel compare, address and match flag
// - cam holds 32 entries of 32 bits
// - don't-care bits never cause mismatch
// - encoded or unencoded 16-line match output
// - unencoded: 31 bits compared, bank select
// - single-match: two-cycle write, one-cycle search
// - multi-match: 16 lines per cycle, two cycles
// - fast multi-match: one cycle, 16 entries
// - write two cycles, three with don't-cares
// - each control/data path register optional
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module erc_ram_cam
  import erc_pkg::*;
#(
  parameter int MEM_WORDS = 256  // 16-bit words of the ram array
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        glb_clr,
  input  wire erc_port_s   a_req,
  input  wire logic        a_wr_ce,
  input  wire logic        a_rd_ce,
  input  wire logic        a_clr,
  output logic [15:0]      a_dout,
  input  wire erc_port_s   b_req,
  input  wire logic        b_wr_ce,
  input  wire logic        b_rd_ce,
  input  wire logic        b_clr,
  output logic [15:0]      b_dout,
  input  wire logic [31:0] cam_key,
  input  wire logic        cam_bank_sel,
  input  wire logic        cam_search,
  input  wire logic        cam_wr,
  input  wire logic [4:0]  cam_wr_addr,
  input  wire logic [31:0] cam_wr_data,
  input  wire logic [31:0] cam_wr_mask,
  input  wire logic        cam_wr_dc,
  output logic             cam_match,
  output logic [4:0]       cam_addr,
  output logic [15:0]      cam_lines,
  output logic             cam_valid,
  output logic             cam_phase,
  output logic             cam_busy
);

  if (MEM_WORDS != 256) begin : g_chk
    $error("erc_ram_cam: addressing serves exactly 256 words");
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  typedef enum logic [1:0] {
    ERC_S_IDLE = 2'b00,  // waiting for write or search
    ERC_S_WDAT = 2'b01,  // second write cycle, care set to all ones
    ERC_S_WDC  = 2'b10,  // third write cycle, care mask committed
    ERC_S_HI   = 2'b11   // second half of a multi-match report
  } erc_cs_e;

  // ram width mask for a log2 width code
  function automatic logic [15:0] w_mask(input logic [2:0] w);
    logic [16:0] m;
    m = (17'h00001 << (17'h00001 << w)) - 17'h00001;
    return m[15:0];
  endfunction : w_mask

  // bit address of a port word; split mode pins the top bit to the half
  function automatic logic [11:0] bit_addr(input logic [11:0] a, input logic [2:0] w,
                                           input logic split, input logic half);
    logic [11:0] b;
    b = a << w;
    if (split) begin
      b = {half, b[10:0]};
    end
    return b;
  endfunction : bit_addr

  // lowest matching entry index
  function automatic logic [4:0] prio(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = ERC_CAM_WORDS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : prio

  logic [31:0]   cfg_reg;                   // configuration register
  logic          soft_clr_reg;              // one-cycle local clear from ctrl
  erc_mode_e     mode;                      // decoded fields
  erc_cam_e      cmode;
  logic [2:0]    wid [2];
  logic [5:0]    opt;
  logic          unenc;
  logic          cfg_err;                   // illegal width combination
  logic [15:0]   mem [MEM_WORDS];           // ram array
  logic [31:0]   cam_data [ERC_CAM_WORDS];  // cam entries
  logic [31:0]   cam_care [ERC_CAM_WORDS];  // 1 = bit compared
  erc_port_s     req [2];
  erc_port_s     q_reg [2];                 // optional input stage
  logic          wr_ce [2];
  logic          rd_ce [2];
  logic          clr [2];
  logic [15:0]   rd_reg [2];                // array read register
  logic [15:0]   dout_reg [2];              // optional output stage
  logic          wstb [2];                  // internal write strobes
  logic          rstb [2];
  logic [7:0]    wword [2];
  logic [3:0]    woff [2];
  logic [7:0]    rword [2];
  logic [3:0]    roff [2];
  logic [15:0]   wm [2];
  logic [15:0]   wdat [2];
  logic [15:0]   wb_base;

  assign req[0]   = a_req;
  assign req[1]   = b_req;
  assign wr_ce[0] = a_wr_ce;
  assign wr_ce[1] = b_wr_ce;
  assign rd_ce[0] = a_rd_ce;
  assign rd_ce[1] = b_rd_ce;
  assign clr[0]   = a_clr | glb_clr | soft_clr_reg;
  assign clr[1]   = b_clr | glb_clr | soft_clr_reg;

  // configuration decode and legality
  always_comb begin
    mode   = erc_mode_e'(cfg_reg[ERC_CFG_MODE_LSB +: 3]);
    cmode  = erc_cam_e'(cfg_reg[ERC_CFG_CAM_LSB +: 2]);
    wid[0] = cfg_reg[ERC_CFG_WA_LSB +: 3];
    wid[1] = cfg_reg[ERC_CFG_WB_LSB +: 3];
    opt    = cfg_reg[ERC_CFG_OPT_LSB +: 6];
    unenc  = cfg_reg[ERC_CFG_UNENC];
    cfg_err = (wid[0] > ERC_W16) || (wid[1] > ERC_W16);
    if (mode == ERC_M_SPLIT) begin
      cfg_err = cfg_err || (wid[0] > ERC_W8) || (wid[0] != wid[1]);
    end
    if (mode == ERC_M_SIMPLE && wid[0] != wid[1]) begin
      cfg_err = cfg_err || (wid[0] != 3'h0 && wid[1] != 3'h0);
    end
  end

  // per-port path: optional registers, width slicing, strobes
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      logic        we_e;
      logic        re_e;
      logic [11:0] wa;
      logic [11:0] ra;
      logic [11:0] wb;
      logic [11:0] rb;
      logic        w_ok;
      logic        r_ok;
      w_ok = 1'b0;  // no port may write unless the mode allows it
      r_ok = 1'b0;
      wb   = 12'h000;
      rb   = 12'h000;
      we_e = opt[ERC_OPT_WE] ? q_reg[p].we : req[p].we;
      re_e = opt[ERC_OPT_RE] ? q_reg[p].re : req[p].re;
      wa   = opt[ERC_OPT_WADDR] ? q_reg[p].addr : req[p].addr;
      ra   = opt[ERC_OPT_RADDR] ? q_reg[p].addr : req[p].addr;
      wdat[p] = opt[ERC_OPT_DIN] ? q_reg[p].din : req[p].din;
      case (mode)
        ERC_M_BIDIR, ERC_M_SPLIT: begin
          w_ok = 1'b1;
          r_ok = 1'b1;
        end
        ERC_M_SIMPLE: begin
          w_ok = (p == 0);
          r_ok = (p == 1);
        end
        ERC_M_SINGLE: begin
          w_ok = (p == 0);
          r_ok = (p == 0);
        end
        ERC_M_ROM: begin
          w_ok = 1'b0;
          r_ok = 1'b1;
        end
        default: begin
          w_ok = 1'b0;
          r_ok = 1'b0;
        end
      endcase
      wb = bit_addr(wa, wid[p], mode == ERC_M_SPLIT, p[0]);
      rb = bit_addr(ra, wid[p], mode == ERC_M_SPLIT, p[0]);
      wword[p] = wb[11:4];
      woff[p]  = wb[3:0];
      rword[p] = rb[11:4];
      roff[p]  = rb[3:0];
      wm[p]    = w_mask(wid[p]) << woff[p];
      // strobe made here, qualified by the write clock enable
      wstb[p]  = w_ok && we_e && wr_ce[p] && !cfg_err && !clr[p];
      rstb[p]  = r_ok && re_e && rd_ce[p] && !cfg_err;
    end
  end

  // port b merges onto a's result when both hit one word, so a's bits outside b's mask are kept
  assign wb_base = (wstb[0] && wword[0] == wword[1]) ?
                   ((mem[wword[0]] & ~wm[0]) | ((wdat[0] << woff[0]) & wm[0])) :
                   mem[wword[1]];

  // input stage, held by each port's write clock enable
  always_ff @(posedge aclk) begin
    for (int p = 0; p < 2; p++) begin
      if (!aresetn || clr[p]) begin
        q_reg[p] <= '0;
      end else if (wr_ce[p]) begin
        q_reg[p] <= req[p];
      end
    end
  end

  // array writes; the array itself is not cleared, only the registers
  always_ff @(posedge aclk) begin
    if (wstb[0]) begin
      mem[wword[0]] <= (mem[wword[0]] & ~wm[0]) | ((wdat[0] << woff[0]) & wm[0]);
    end
    if (wstb[1]) begin
      mem[wword[1]] <= (wb_base & ~wm[1]) | ((wdat[1] << woff[1]) & wm[1]);
    end
  end

  // read register, then optional output pipeline on the read clock enable
  always_ff @(posedge aclk) begin
    for (int p = 0; p < 2; p++) begin
      if (!aresetn || clr[p]) begin
        rd_reg[p]   <= '0;
        dout_reg[p] <= '0;
      end else begin
        if (rstb[p]) begin
          rd_reg[p] <= (mem[rword[p]] >> roff[p]) & w_mask(wid[p]);
        end
        if (rd_ce[p]) begin
          dout_reg[p] <= rd_reg[p];
        end
      end
    end
  end

  assign a_dout = opt[ERC_OPT_DOUT] ? dout_reg[0] : rd_reg[0];
  assign b_dout = opt[ERC_OPT_DOUT] ? dout_reg[1] : rd_reg[1];

  // ---------------- cam ----------------
  erc_cs_e      cs_reg;
  logic [4:0]   cw_addr_reg;
  logic [31:0]  cw_mask_reg;
  logic         cw_dc_reg;
  logic [31:0]  hit;
  logic [31:0]  kmask;
  logic [15:0]  sel_lines;
  logic         cam_on;
  logic         cam_wr_go;
  logic         cam_sr_go;

  assign cam_on    = (mode == ERC_M_CAM) && !glb_clr && !soft_clr_reg;
  assign cam_wr_go = cam_on && cs_reg == ERC_S_IDLE && cam_wr &&
                     !(cmode == ERC_C_FAST && cam_wr_addr[4]);
  assign cam_sr_go = cam_on && cs_reg == ERC_S_IDLE && cam_search && !cam_wr;
  assign cam_busy  = cs_reg != ERC_S_IDLE;
  assign kmask     = unenc ? ERC_KEY_UNENC : '1;

  // parallel compare of every entry
  always_comb begin
    for (int i = 0; i < ERC_CAM_WORDS; i++) begin
      hit[i] = (((cam_key ^ cam_data[i]) & cam_care[i] & kmask) == 32'h0000_0000);
      if (cmode == ERC_C_FAST && i >= ERC_CAM_FAST) begin
        hit[i] = 1'b0;
      end
    end
    for (int j = 0; j < ERC_CAM_LINES; j++) begin
      sel_lines[j] = hit[2 * j + int'(cam_bank_sel)];
    end
  end

  // cam sequencer: write takes two cycles, three with a care mask
  always_ff @(posedge aclk) begin
    if (!aresetn || glb_clr || soft_clr_reg) begin
      cs_reg      <= ERC_S_IDLE;
      cw_addr_reg <= '0;
      cw_mask_reg <= '0;
      cw_dc_reg   <= 1'b0;
    end else begin
      case (cs_reg)
        ERC_S_IDLE: begin
          if (cam_wr_go) begin
            cw_addr_reg <= cam_wr_addr;
            cw_mask_reg <= cam_wr_mask;
            cw_dc_reg   <= cam_wr_dc;
            cs_reg      <= ERC_S_WDAT;
          end else if (cam_sr_go && cmode == ERC_C_MULTI) begin
            cs_reg <= ERC_S_HI;
          end
        end
        ERC_S_WDAT: cs_reg <= cw_dc_reg ? ERC_S_WDC : ERC_S_IDLE;
        ERC_S_WDC:  cs_reg <= ERC_S_IDLE;
        ERC_S_HI:   cs_reg <= ERC_S_IDLE;
        default:    cs_reg <= ERC_S_IDLE;
      endcase
    end
  end

  // entry storage: data on the first cycle, care all ones on the second, care mask on the third
  always_ff @(posedge aclk) begin
    if (cs_reg == ERC_S_IDLE && cam_wr_go) begin
      cam_data[cam_wr_addr] <= cam_wr_data;
    end
    if (cs_reg == ERC_S_WDAT) begin
      cam_care[cw_addr_reg] <= '1;
    end
    if (cs_reg == ERC_S_WDC) begin
      cam_care[cw_addr_reg] <= ~cw_mask_reg;
    end
  end

  // search results; key must stay put across a multi-match pair
  always_ff @(posedge aclk) begin
    if (!aresetn || glb_clr || soft_clr_reg) begin
      cam_match <= 1'b0;
      cam_addr  <= '0;
      cam_lines <= '0;
      cam_valid <= 1'b0;
      cam_phase <= 1'b0;
    end else begin
      cam_valid <= 1'b0;
      cam_phase <= 1'b0;
      if (cam_sr_go) begin
        cam_valid <= 1'b1;
        cam_match <= |hit;
        cam_addr  <= prio(hit);
        if (cmode == ERC_C_SINGLE && unenc) begin
          cam_lines <= sel_lines;
        end else begin
          cam_lines <= hit[15:0];
        end
      end else if (cs_reg == ERC_S_HI) begin
        cam_valid <= 1'b1;
        cam_phase <= 1'b1;
        cam_lines <= hit[31:16];
      end
    end
  end

  // ---------------- axi4-lite slave ----------------
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [3:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_do;

  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_do         = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  // address and data are caught in either order, answered once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      aw_addr_reg  <= '0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ERC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg == ERC_OFF_CFG || aw_addr_reg == ERC_OFF_CTRL) ?
                        ERC_RESP_OKAY : ERC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration register with byte lanes; ctrl clear is a pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg      <= ERC_CFG_RST;
      soft_clr_reg <= 1'b0;
    end else begin
      soft_clr_reg <= wr_do && aw_addr_reg == ERC_OFF_CTRL &&
                      w_strb_reg[0] && w_data_reg[ERC_CTRL_CLR];
      if (wr_do && aw_addr_reg == ERC_OFF_CFG) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb_reg[b]) begin
            cfg_reg[8 * b +: 8] <= w_data_reg[8 * b +: 8];
          end
        end
      end
    end
  end

  // read channel: one cycle to data, unmapped reads zero with slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= ERC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= ERC_RESP_OKAY;
      s_axi_rdata  <= '0;
      case (s_axi_araddr)
        ERC_OFF_CFG:  s_axi_rdata <= cfg_reg;
        ERC_OFF_CTRL: s_axi_rdata <= '0;
        ERC_OFF_STATUS: begin
          s_axi_rdata[ERC_ST_MATCH]         <= cam_match;
          s_axi_rdata[ERC_ST_ERR]           <= cfg_err;
          s_axi_rdata[ERC_ST_BUSY]          <= cam_busy;
          s_axi_rdata[ERC_ST_ADDR_LSB +: 5] <= cam_addr;
        end
        default: s_axi_rresp <= ERC_RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- checks ----------------
  axi_b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  axi_r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  width_legal_a: assert property (cfg_err |-> !wstb[0] && !wstb[1])
    else $error("write with illegal width setting");
  cam_no_hit_a: assert property (cam_valid && !cam_phase && !cam_match |-> cam_addr == 5'h00)
    else $error("address nonzero without match");
  cam_wr_two_a: assert property (cam_wr_go && !cam_wr_dc |=> cam_busy ##1 !cam_busy)
    else $error("plain cam write not two cycles");
  cam_wr_three_a: assert property (cam_wr_go && cam_wr_dc |=> cam_busy [*2] ##1 !cam_busy)
    else $error("cam care write not three cycles");
  cam_multi_pair_a: assert property (cam_sr_go && cmode == ERC_C_MULTI
      |=> cam_valid && !cam_phase ##1 cam_valid && cam_phase)
    else $error("multi-match report not two cycles");
  cam_search_one_a: assert property (cam_sr_go |=> cam_valid && cam_match == $past(|hit))
    else $error("search result wrong or late");
  port_clear_a: assert property (clr[0] |=> rd_reg[0] == 16'h0000)
    else $error("port a clear ignored");
  cov_match_c: cover property (cam_valid && cam_match);
  cov_multi_c: cover property (cam_valid && cam_phase);
  cov_dual_wr_c: cover property (wstb[0] && wstb[1]);

endmodule : erc_ram_cam

// ===== erc_pkg.sv
// shared constants and carrier types for the embedded ram/cam block
package erc_pkg;
  // register byte offsets on the control bus
  localparam logic [3:0] ERC_OFF_CFG    = 4'h0;
  localparam logic [3:0] ERC_OFF_CTRL   = 4'h4;
  localparam logic [3:0] ERC_OFF_STATUS = 4'h8;
  // configuration field positions
  localparam int ERC_CFG_MODE_LSB = 0;   // 3 bits, memory mode
  localparam int ERC_CFG_WA_LSB   = 4;   // 3 bits, log2 width of port a
  localparam int ERC_CFG_WB_LSB   = 8;   // 3 bits, log2 width of port b
  localparam int ERC_CFG_CAM_LSB  = 12;  // 2 bits, cam output mode
  localparam int ERC_CFG_UNENC    = 14;  // unencoded cam lines
  localparam int ERC_CFG_OPT_LSB  = 16;  // 6 bits, optional registers
  localparam logic [31:0] ERC_CFG_RST = 32'h0000_0000;
  // optional register selects within the option field
  localparam int ERC_OPT_DIN   = 0;
  localparam int ERC_OPT_DOUT  = 1;
  localparam int ERC_OPT_RADDR = 2;
  localparam int ERC_OPT_WADDR = 3;
  localparam int ERC_OPT_WE    = 4;
  localparam int ERC_OPT_RE    = 5;
  // control and status bit positions
  localparam int ERC_CTRL_CLR    = 0;
  localparam int ERC_ST_MATCH    = 0;
  localparam int ERC_ST_ERR      = 1;
  localparam int ERC_ST_BUSY     = 2;
  localparam int ERC_ST_ADDR_LSB = 8;
  // bus responses
  localparam logic [1:0] ERC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] ERC_RESP_SLVERR = 2'b10;
  // array geometry
  localparam int ERC_CAM_WORDS = 32;
  localparam int ERC_CAM_FAST  = 16;
  localparam int ERC_CAM_LINES = 16;
  localparam logic [2:0] ERC_W16 = 3'h4;  // log2 of 16-bit width
  localparam logic [2:0] ERC_W8  = 3'h3;
  localparam logic [31:0] ERC_KEY_UNENC = 32'h7FFF_FFFF;

  typedef enum logic [2:0] {
    ERC_M_BIDIR  = 3'b000,  // two read/write ports
    ERC_M_SIMPLE = 3'b001,  // a writes, b reads
    ERC_M_SINGLE = 3'b010,  // port a only
    ERC_M_SPLIT  = 3'b011,  // two half-size single-port rams
    ERC_M_ROM    = 3'b100,  // reads only
    ERC_M_CAM    = 3'b101   // content addressable
  } erc_mode_e;

  typedef enum logic [1:0] {
    ERC_C_SINGLE = 2'b00,
    ERC_C_MULTI  = 2'b01,
    ERC_C_FAST   = 2'b10
  } erc_cam_e;

  // one memory port request
  typedef struct packed {
    logic        we;
    logic        re;
    logic [11:0] addr;
    logic [15:0] din;
  } erc_port_s;
endpackage : erc_pkg

// ===== erc_user.sv
// user-logic model that loads and searches the cam from the fabric side
`timescale 1ns/100ps
module erc_user (
  input  wire logic   aclk,
  input  wire logic   cam_busy,
  output logic [31:0] cam_key,
  output logic        cam_bank_sel,
  output logic        cam_search,
  output logic        cam_wr,
  output logic [4:0]  cam_wr_addr,
  output logic [31:0] cam_wr_data,
  output logic [31:0] cam_wr_mask,
  output logic        cam_wr_dc
);
  // quiet levels at time zero; bank select stays on the even bank
  initial begin
    {cam_key, cam_search, cam_wr, cam_wr_addr} = '0;
    {cam_wr_data, cam_wr_mask, cam_wr_dc} = '0;
    cam_bank_sel = 1'b0;
  end
  // one entry write, then wait out busy so the next request is never refused
  task automatic write_entry(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge aclk);
    cam_wr <= 1'b1;
    cam_wr_addr <= a;
    cam_wr_data <= d;
    cam_wr_mask <= m;
    cam_wr_dc <= |m;
    @(posedge aclk);
    cam_wr <= 1'b0;
    #1;
    // busy lasts one or two cycles depending on the care-mask pass
    while (cam_busy === 1'b1) begin
      @(posedge aclk);
      #1;
    end
  endtask : write_entry
  // one search pulse; the key stays put over the whole result window
  task automatic search(input logic [31:0] k);
    @(posedge aclk);
    cam_key <= k;
    cam_search <= 1'b1;
    @(posedge aclk);
    cam_search <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : search
endmodule : erc_user

// ===== erc_ram_cam_test.sv
// self-checking bench for the embedded ram/cam block
`timescale 1ns/100ps
module erc_ram_cam_test import erc_pkg::*;;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, cam_key, cam_wr_data, cam_wr_mask;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        cam_match, cam_valid, cam_phase, cam_busy, cam_bank_sel, cam_search;
  logic        cam_wr, cam_wr_dc;
  logic [4:0]  cam_addr, cam_wr_addr;
  logic [15:0] a_dout, b_dout, cam_lines;
  erc_port_s   a_req = '0, b_req = '0;  // port requests
  logic        a_wr_ce = 1'b1, b_wr_ce = 1'b1, a_rd_ce = 1'b1, b_rd_ce = 1'b1;
  logic        a_clr = 1'b0, b_clr = 1'b0, glb_clr = 1'b0;  // clears left idle
  int          fails = 0, checked = 0, cyc = 0;
  int          pick[4] = '{3, 7, 20, 31};  // entries searched by stored key; 3 with don't-care bits and 7 (unencoded) with bit 31 flipped
  logic [31:0] rs = 32'hB965, d0, d1, k;
  logic [31:0] dat[32], msk[32];  // reference copy of the cam contents
  logic [33:0] expq[$];  // expected results, oldest first

  erc_ram_cam dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .glb_clr, .a_req, .a_wr_ce, .a_rd_ce, .a_clr, .a_dout,
    .b_req, .b_wr_ce, .b_rd_ce, .b_clr, .b_dout, .cam_key, .cam_bank_sel, .cam_search,
    .cam_wr, .cam_wr_addr, .cam_wr_data, .cam_wr_mask, .cam_wr_dc, .cam_match, .cam_addr,
    .cam_lines, .cam_valid, .cam_phase, .cam_busy);
  erc_user u_usr (.aclk, .cam_busy, .cam_key, .cam_bank_sel, .cam_search, .cam_wr,
    .cam_wr_addr, .cam_wr_data, .cam_wr_mask, .cam_wr_dc);

  always #5 aclk = ~aclk;  // 100 MHz
  // xorshift source for data and keys
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  // expected {phase, lines, match, lowest entry}; mode 3 stands for single unencoded
  function automatic logic [33:0] cam_ref(input logic [31:0] key, input logic [1:0] cm,
                                          input logic ph);
    logic [31:0] h;
    logic [33:0] e;
    h = 32'h0;
    e = 34'h0;
    for (int i = 0; i < ERC_CAM_WORDS; i++) begin
      if (((dat[i] ^ key) & ~msk[i] & ((cm == 2'h3) ? ERC_KEY_UNENC : 32'hFFFF_FFFF)) == 32'h0
          && !(cm == ERC_C_FAST && i >= ERC_CAM_FAST)) begin
        h[i] = 1'b1;
        if (!e[5]) e[5:0] = {1'b1, i[4:0]};
      end
    end
    for (int j = 0; j < ERC_CAM_LINES; j++)
      e[6 + j] = (cm == 2'h3) ? h[2 * j] : h[j + (ph ? 16 : 0)];
    e[22] = ph;
    return e;
  endfunction : cam_ref
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // write: address and data offered together, each released when taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {32'h0, s_axi_bresp}, {32'h0, r});
  endtask : axw
  // read: expectation noted first, the monitor compares the answer
  task automatic axr(input logic [3:0] a, input logic [33:0] e);
    @(posedge aclk);
    expq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axr
  // monitor: results looked at mid-cycle, where they are settled
  always @(negedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk("read", {s_axi_rresp, s_axi_rdata}, expq.pop_front());
    if (cam_valid === 1'b1)
      chk("search", {11'h0, cam_phase, cam_lines, cam_match, cam_addr}, expq.pop_front());
  end
  // hang guard, far above the run's real length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(ERC_OFF_CFG, {ERC_RESP_OKAY, ERC_CFG_RST});
    axr(4'hC, {ERC_RESP_SLVERR, 32'h0});
    axw(ERC_OFF_STATUS, 32'h0, ERC_RESP_SLVERR);
    axw(ERC_OFF_CFG, 32'h0000_0231, ERC_RESP_OKAY);
    axr(ERC_OFF_STATUS, {ERC_RESP_OKAY, 32'h0000_0002});
    // bidir 16-bit: two writes, two crossed reads; second pass with every optional register
    for (int o = 0; o < 2; o++) begin
      axw(ERC_OFF_CFG, (o == 1) ? 32'h003F_0440 : 32'h0000_0440, ERC_RESP_OKAY);
      d0 = rnd();
      d1 = rnd();
      @(posedge aclk);
      a_req <= '{1'b1, 1'b0, 12'h015, d0[15:0]};
      b_req <= '{1'b1, 1'b0, 12'h016, d1[15:0]};
      @(posedge aclk);
      a_req <= '{1'b0, 1'b1, 12'h016, 16'h0};
      b_req <= '{1'b0, 1'b1, 12'h015, 16'h0};
      repeat (2) @(posedge aclk);
      a_req <= '0;
      b_req <= '0;
      if (o == 1) @(posedge aclk);
      @(negedge aclk);
      chk("a_dout", {18'h0, a_dout}, {18'h0, d1[15:0]});
      chk("b_dout", {18'h0, b_dout}, {18'h0, d0[15:0]});
    end
    // cam: load all entries, a duplicate at 9 and a masked entry at 3
    axw(ERC_OFF_CFG, 32'h0000_0005, ERC_RESP_OKAY);
    for (int i = 0; i < ERC_CAM_WORDS; i++) begin
      dat[i] = (i == 9) ? dat[7] : rnd();
      msk[i] = (i == 3) ? 32'h0000_FFFF : 32'h0;
      u_usr.write_entry(i[4:0], dat[i], msk[i]);
    end
    // single, multi, fast, then single unencoded on the even bank
    for (int f = 0; f < 4; f++) begin
      if (f > 0) axw(ERC_OFF_CFG, (f == 3) ? 32'h0000_4005 : 32'h0000_0005 + 32'(f << 12),
                     ERC_RESP_OKAY);
      for (int j = 0; j < 8; j++) begin
        k = (j < 4) ? dat[pick[j]] : rnd();
        if (j == 0) k = k ^ 32'h0000_0F0F;
        if (j == 1 && f == 3) k[31] = ~k[31];
        expq.push_back(cam_ref(k, f[1:0], 1'b0));
        if (f == 1) expq.push_back(cam_ref(k, f[1:0], 1'b1));
        u_usr.search(k);
      end
    end
    axw(ERC_OFF_CTRL, 32'h0000_0001, ERC_RESP_OKAY);
    axr(ERC_OFF_STATUS, {ERC_RESP_OKAY, 32'h0});
    axr(ERC_OFF_CTRL, {ERC_RESP_OKAY, 32'h0});
    repeat (4) @(posedge aclk);
    wrap_up();
  end
endmodule : erc_ram_cam_test
